// >>> rtl/dzcal_pkg.sv
// constants and types for the impedance calibration sequencer
// What this block does
// - long command runs engine, then transfers codes
// - long command at power-up or any later time while idle; dropped while busy
// - first long after reset gets initial period
// - later long commands get operational period
// - short command calibrates within short period
// - short command corrects error within 128 cycles
// - calibration current path off once done
// - no self-started recalibration on self-refresh exit
// - termination input low; parked termination kept
package dzcal_pkg;
    localparam int unsigned DZCAL_CLK_PERIOD_PS = 4000;
    localparam int unsigned DZCAL_CORR_CYCLES = 128;
    localparam int unsigned DZCAL_INIT_CYCLES = 1024;
    localparam int unsigned DZCAL_OPER_CYCLES = 512;
    localparam int unsigned DZCAL_SHORT_CYCLES = 128;
    localparam int unsigned DZCAL_CNT_W = 16;
    localparam int unsigned DZCAL_CODE_W = 6;
    localparam logic [5:0] DZCAL_CODE_RST = 6'h20;
    localparam logic [5:0] DZCAL_CODE_ONE = 6'h01;
    localparam int unsigned DZCAL_LOAD_OFFSET = 2;
    localparam int unsigned DZCAL_CNT_STEP = 1;
    typedef enum logic [3:0] {
        DZCAL_IDLE = 4'h1,
        DZCAL_RUN = 4'h2,
        DZCAL_XFER = 4'h4,
        DZCAL_DONE = 4'h8
    } dzcal_state_t;
endpackage

// >>> rtl/dzcal_engine.sv
// successive step engine comparing against external reference
`timescale 1ns/100ps
`default_nettype none
module dzcal_engine
    import dzcal_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic step_en,
    input wire logic cmp_high,
    // result
    output logic [DZCAL_CODE_W-1:0] code
);
    logic [DZCAL_CODE_W-1:0] code_q;
    logic [DZCAL_CODE_W-1:0] code_d;
    wire at_max = (code_q == {DZCAL_CODE_W{1'b1}});
    wire at_min = (code_q == '0);

    assign code_d = !step_en ? code_q :
                    (cmp_high && !at_max) ? code_q + DZCAL_CODE_ONE :
                    (!cmp_high && !at_min) ? code_q - DZCAL_CODE_ONE : code_q;
    assign code = code_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            code_q <= DZCAL_CODE_RST;
        end else begin
            code_q <= code_d;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dzcal_ctrl.sv
// device-side impedance calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module dzcal_ctrl
    import dzcal_pkg::*;
#(
    parameter int unsigned INIT_CYCLES = DZCAL_INIT_CYCLES,
    parameter int unsigned OPER_CYCLES = DZCAL_OPER_CYCLES,
    parameter int unsigned SHORT_CYCLES = DZCAL_SHORT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // decoded commands, same domain
    input wire logic long_impedance_cal_cmd,
    input wire logic short_impedance_cal_cmd,
    input wire logic self_refresh_exit,
    // comparator from resistor pin
    input wire logic cal_cmp_pin,
    // outputs
    output logic [DZCAL_CODE_W-1:0] drive_code,
    output logic [DZCAL_CODE_W-1:0] term_code,
    output logic cal_current_en,
    output logic park_term_hold,
    output logic cal_busy
);
    ////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic cmp_s1_q;
    logic cmp_s2_q;

    // sequencer state
    dzcal_state_t state_q;
    dzcal_state_t state_d;

    // period counter
    logic [DZCAL_CNT_W-1:0] cnt_q;
    logic [DZCAL_CNT_W-1:0] cnt_d;

    // first long command since reset
    logic first_done_q;
    logic first_done_d;

    // codes seen by the io
    logic [DZCAL_CODE_W-1:0] drive_q;
    logic [DZCAL_CODE_W-1:0] drive_d;
    logic [DZCAL_CODE_W-1:0] term_q;
    logic [DZCAL_CODE_W-1:0] term_d;

    // engine result
    logic [DZCAL_CODE_W-1:0] eng_code;

    ////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic in_state(input dzcal_state_t cur, input dzcal_state_t want);
        in_state = (cur == want);
    endfunction

    function automatic logic [DZCAL_CNT_W-1:0] period_load(input int unsigned cycles);
        period_load = DZCAL_CNT_W'(cycles) - DZCAL_CNT_W'(DZCAL_LOAD_OFFSET);
    endfunction

    function automatic logic [DZCAL_CODE_W-1:0] take_code(
        input logic sel,
        input logic [DZCAL_CODE_W-1:0] fresh,
        input logic [DZCAL_CODE_W-1:0] held
    );
        take_code = sel ? fresh : held;
    endfunction

    ////////////////////////////////////////////////////////////////
    // state decode
    wire st_idle = in_state(state_q, DZCAL_IDLE);
    wire st_run = in_state(state_q, DZCAL_RUN);
    wire st_xfer = in_state(state_q, DZCAL_XFER);

    ////////////////////////////////////////////////////////////////
    // command acceptance; long wins, busy drops both
    wire long_req = st_idle && long_impedance_cal_cmd;
    wire short_req = st_idle && short_impedance_cal_cmd && !long_impedance_cal_cmd;
    wire any_req = long_req || short_req;
    // self refresh exit alone never starts the engine
    wire srx_only = st_idle && self_refresh_exit && !any_req;

    ////////////////////////////////////////////////////////////////
    // period selection
    wire [DZCAL_CNT_W-1:0] init_load = period_load(INIT_CYCLES);
    wire [DZCAL_CNT_W-1:0] oper_load = period_load(OPER_CYCLES);
    wire [DZCAL_CNT_W-1:0] short_load = period_load(SHORT_CYCLES);
    wire [DZCAL_CNT_W-1:0] long_load = first_done_q ? oper_load : init_load;
    wire [DZCAL_CNT_W-1:0] run_load = long_req ? long_load : short_load;

    ////////////////////////////////////////////////////////////////
    // period counter
    wire cnt_zero = (cnt_q == '0);
    wire [DZCAL_CNT_W-1:0] cnt_dec = cnt_q - DZCAL_CNT_W'(DZCAL_CNT_STEP);
    wire cnt_run = st_run && !cnt_zero;
    wire run_end = st_run && cnt_zero;

    always_comb begin
        cnt_d = cnt_q;
        if (any_req) begin
            cnt_d = run_load;
        end else if (cnt_run) begin
            cnt_d = cnt_dec;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequencer: run, transfer, settle, back to idle
    always_comb begin
        state_d = state_q;
        case (state_q)
            DZCAL_IDLE: begin
                if (any_req) begin
                    state_d = DZCAL_RUN;
                end else if (srx_only) begin
                    state_d = DZCAL_IDLE;
                end
            end
            DZCAL_RUN: begin
                if (run_end) begin
                    state_d = DZCAL_XFER;
                end
            end
            DZCAL_XFER: begin
                state_d = DZCAL_DONE;
            end
            DZCAL_DONE: begin
                state_d = DZCAL_IDLE;
            end
            default: begin
                state_d = DZCAL_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // first long command since reset
    always_comb begin
        first_done_d = first_done_q;
        if (long_req) begin
            first_done_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // calibration engine, steps only while running
    wire eng_step = st_run;
    dzcal_engine u_engine (
        .clk(clk),
        .reset(reset),
        .step_en(eng_step),
        .cmp_high(cmp_s2_q),
        .code(eng_code)
    );

    ////////////////////////////////////////////////////////////////
    // transfer to the io in one cycle
    assign drive_d = take_code(st_xfer, eng_code, drive_q);
    assign term_d = take_code(st_xfer, eng_code, term_q);

    ////////////////////////////////////////////////////////////////
    // outputs
    wire busy = !st_idle;
    assign drive_code = drive_q;
    assign term_code = term_q;
    assign cal_current_en = st_run;
    assign park_term_hold = busy;
    assign cal_busy = busy;

    ////////////////////////////////////////////////////////////////
    // registers
    // synchroniser, two stages, no reset
    always_ff @(posedge clk) begin
        cmp_s1_q <= cal_cmp_pin;
        cmp_s2_q <= cmp_s1_q;
    end

    // sequencer state
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= DZCAL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // period counter
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // first long flag
    always_ff @(posedge clk) begin
        if (reset) begin
            first_done_q <= 1'b0;
        end else begin
            first_done_q <= first_done_d;
        end
    end

    // driver code
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_q <= DZCAL_CODE_RST;
        end else begin
            drive_q <= drive_d;
        end
    end

    // termination code
    always_ff @(posedge clk) begin
        if (reset) begin
            term_q <= DZCAL_CODE_RST;
        end else begin
            term_q <= term_d;
        end
    end
endmodule
`default_nettype wire

// >>> bench/dzcal_ctrl_assertions.sv
// concurrent checks for the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module dzcal_chk
    import dzcal_pkg::*;
#(parameter int unsigned INIT_CYCLES = 8, OPER_CYCLES = 6, SHORT_CYCLES = 4) (
    // clock, reset, commands
    input wire logic clk,
    input wire logic reset,
    input wire logic long_impedance_cal_cmd,
    input wire logic short_impedance_cal_cmd,
    input wire logic self_refresh_exit,
    // status and codes
    input wire logic [DZCAL_CODE_W-1:0] drive_code,
    input wire logic [DZCAL_CODE_W-1:0] term_code,
    input wire logic cal_current_en,
    input wire logic park_term_hold,
    input wire logic cal_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic seen_q;
    int unsigned cnt_q, exp_q;
    wire take = (long_impedance_cal_cmd | short_impedance_cal_cmd) & !cal_busy;
    always_ff @(posedge clk) begin
        if (reset) begin
            seen_q <= 1'b0;
            cnt_q <= 0;
            exp_q <= 0;
        end else if (take) begin
            seen_q <= seen_q | long_impedance_cal_cmd;
            cnt_q <= 0;
            exp_q <= !long_impedance_cal_cmd ? SHORT_CYCLES : seen_q ? OPER_CYCLES : INIT_CYCLES;
        end else if (cal_busy) begin
            cnt_q <= cnt_q + 1;
        end
    end
    property p_start; take |=> cal_busy; endproperty
    a_start: assert property (p_start) else $error("no busy");
    property p_len; $fell(cal_busy) |-> cnt_q >= exp_q && cnt_q <= exp_q + 2; endproperty
    a_len: assert property (p_len) else $error("bad span");
    property p_cur_on; take |=> cal_current_en; endproperty
    a_cur_on: assert property (p_cur_on) else $error("no engine");
    property p_cur_in; cal_current_en |-> cal_busy; endproperty
    a_cur_in: assert property (p_cur_in) else $error("stray current");
    property p_cur_off; $fell(cal_current_en) |-> ##[0:3] !cal_busy; endproperty
    a_cur_off: assert property (p_cur_off) else $error("late idle");
    property p_eq; drive_code == term_code && park_term_hold == cal_busy; endproperty
    a_eq: assert property (p_eq) else $error("codes or park");
    property p_hold; !cal_busy |=> $stable(drive_code); endproperty
    a_hold: assert property (p_hold) else $error("code moved idle");
    property p_srx; self_refresh_exit && !take && !cal_busy |=> !cal_busy; endproperty
    a_srx: assert property (p_srx) else $error("self cal");
    c_long: cover property (take && long_impedance_cal_cmd);
    c_short: cover property (take && short_impedance_cal_cmd);
    c_srx: cover property (self_refresh_exit && !cal_busy);
endmodule
bind dzcal_ctrl dzcal_chk #(.INIT_CYCLES(INIT_CYCLES), .OPER_CYCLES(OPER_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)) u_chk (.clk(clk), .reset(reset),
    .long_impedance_cal_cmd(long_impedance_cal_cmd), .self_refresh_exit(self_refresh_exit),
    .short_impedance_cal_cmd(short_impedance_cal_cmd), .drive_code(drive_code),
    .term_code(term_code), .cal_current_en(cal_current_en), .park_term_hold(park_term_hold),
    .cal_busy(cal_busy));
`default_nettype wire

// >>> bench/dzcal_host.sv
// controller model issuing calibration commands
`timescale 1ns/100ps
`default_nettype none
module dzcal_host (
    // status in
    input wire logic clk,
    input wire logic cal_busy,
    // commands and resistor level out
    output logic long_impedance_cal_cmd,
    output logic short_impedance_cal_cmd,
    output logic cal_cmp_pin
);
    initial begin
        long_impedance_cal_cmd = 1'b0;
        short_impedance_cal_cmd = 1'b0;
        cal_cmp_pin = 1'b0;
    end
    task automatic issue(input logic lng, input logic lvl, input int slow);
        cal_cmp_pin = lvl;
        repeat (slow) @(negedge clk);
        while (cal_busy !== 1'b0) @(negedge clk);
        long_impedance_cal_cmd = lng;
        short_impedance_cal_cmd = !lng;
        @(negedge clk);
        long_impedance_cal_cmd = 1'b0;
        short_impedance_cal_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> bench/dzcal_ctrl_bench.sv
// bench for the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", n, e, s); end end
module dzcal_ctrl_bench;
    import dzcal_pkg::*;
    localparam int unsigned INI = 12, OPE = 6, SHO = 3;
    logic clk = 0, reset = 1, srx = 0;
    logic lc, sc, cmp, cur, park, busy;
    logic [DZCAL_CODE_W-1:0] dc, tc, old;
    int fails = 0, total_checks = 0, n;
    always #2 clk = ~clk;
    dzcal_host host (.clk(clk), .cal_busy(busy), .long_impedance_cal_cmd(lc),
        .short_impedance_cal_cmd(sc), .cal_cmp_pin(cmp));
    dzcal_ctrl #(.INIT_CYCLES(INI), .OPER_CYCLES(OPE), .SHORT_CYCLES(SHO)) uut (.clk(clk),
        .reset(reset), .long_impedance_cal_cmd(lc), .short_impedance_cal_cmd(sc),
        .self_refresh_exit(srx), .cal_cmp_pin(cmp), .drive_code(dc), .term_code(tc),
        .cal_current_en(cur), .park_term_hold(park), .cal_busy(busy));
    task automatic run(input logic lng, input logic lvl, input int slow, input int lo);
        old = dc;
        host.issue(lng, lvl, slow);
        `CHK("engine on", 2'b11, {cur, park})
        n = 0;
        while (busy === 1'b1 && n < 2000) begin
            n++;
            @(negedge clk);
        end
        `CHK("busy span", 1'b1, n >= lo && n <= lo + 2)
        `CHK("current off", 1'b0, cur)
        `CHK("paired", {dc, park}, {tc, 1'b0})
        `CHK("code moved", 1'b1, lvl ? dc > old : dc < old)
    endtask
    task automatic t_first; run(1, 1, 4, INI); endtask
    task automatic t_oper; run(1, 1, 0, OPE); endtask
    task automatic t_short; run(0, 0, 5, SHO); endtask
    task automatic t_srx;
        old = dc;
        srx = 1;
        @(negedge clk);
        srx = 0;
        repeat (4) @(negedge clk);
        `CHK("no self cal", 2'b00, {busy, cur})
        `CHK("codes held", old, dc)
        run(0, 1, 4, SHO);
    endtask
    task automatic t_reset;
        reset = 1;
        repeat (3) @(negedge clk);
        reset = 0;
        `CHK("reset code", DZCAL_CODE_RST, dc)
        run(1, 0, 4, INI);
    endtask
    task automatic report_and_stop;
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        reset = 0;
        t_first;
        t_oper;
        t_short;
        t_srx;
        t_reset;
        report_and_stop;
    end
    initial begin
        #2000;
        fails++;
        report_and_stop;
    end
endmodule
`default_nettype wire
